/* File: hdl/ccam_top.sv */
// Charge counter, calibration timer and coherent ADC result registers.
// Assumes the I2C target delivers byte register accesses on mclk and the
// analog side delivers raw pulse and reference levels that need syncing.
`timescale 1ns/100ps
module ccam_top (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Register transaction port
    input  wire logic        reg_sel,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Raw analog-side levels
    input  wire logic        first_output_pulse,
    input  wire logic        second_output_pulse,
    input  wire logic        third_output_pulse,
    input  wire logic        ref_10mhz,
    input  wire logic        secondary_supply_valid,
    input  wire logic        third_ldo_powering,
    // Converter mode status
    input  wire logic [2:0]  first_conv_mode_field,
    input  wire logic [2:0]  second_conv_mode_field,
    // ADC macro
    output logic             adc_start,
    output logic             adc_use_secondary,
    input  wire logic        adc_done,
    input  wire logic [11:0] adc_voltage,
    input  wire logic [11:0] adc_temperature,
    // Regulator control
    output logic [2:0]       regulator_on,
    output logic [2:0]       coarse_reg_enable,
    output logic [2:0]       first_conv_force_mode,
    output logic [2:0]       second_conv_force_mode,
    output logic             cal_load_on,
    output logic [1:0]       cal_output_select,
    output logic [2:0]       cal_load_level,
    // Open-drain interrupt
    output logic             irq_out,
    output logic             irq_oe_n
);
    logic [1:0] rst_sync_r;
    logic       rst_ok_n;
    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) rst_sync_r <= 2'h0;
        else        rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_ok_n = rst_sync_r[1];

    // Three-stage pin syncs; a level counts once stages two and three agree
    logic [ccam_pkg::SYNC_W-1:0] raw_in, s1_r, s2_r, s3_r, filt_r, rise;
    assign raw_in = {third_ldo_powering, secondary_supply_valid, ref_10mhz,
                     third_output_pulse, second_output_pulse, first_output_pulse};
    genvar gi;
    generate
        for (gi = 0; gi < ccam_pkg::SYNC_W; gi++) begin : g_sync
            always_ff @(posedge mclk or negedge rst_ok_n) begin
                if (!rst_ok_n) begin
                    s1_r[gi]   <= 1'b0;
                    s2_r[gi]   <= 1'b0;
                    s3_r[gi]   <= 1'b0;
                    filt_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= raw_in[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) filt_r[gi] <= s3_r[gi];
                end
            end
            assign rise[gi] = (s2_r[gi] == s3_r[gi]) && s3_r[gi] && !filt_r[gi];
        end
    endgenerate

    // Configuration registers
    logic [7:0] counter_control_r, cal_cfg_r, conv1_r, conv2_r, mask_r, adc_ctrl_r, energy_r;
    logic [7:0] rdata_r, shadow_r;
    logic       cmd_wr;
    assign cmd_wr = reg_wr && (reg_addr == ccam_pkg::A_CMD);
    // Writes stay accepted in every energy mode
    always_ff @(posedge mclk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            counter_control_r  <= 8'h00;
            cal_cfg_r  <= 8'h00;
            conv1_r    <= 8'h00;
            conv2_r    <= 8'h00;
            mask_r     <= 8'h00;
            adc_ctrl_r <= 8'h00;
            energy_r   <= 8'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                ccam_pkg::A_COUNTER_CONTROL:   counter_control_r  <= reg_wdata;
                ccam_pkg::A_CAL_CFG:   cal_cfg_r  <= reg_wdata;
                ccam_pkg::A_CONV1_CTL: conv1_r    <= reg_wdata;
                ccam_pkg::A_CONV2_CTL: conv2_r    <= reg_wdata;
                ccam_pkg::A_STAT_MASK: mask_r     <= reg_wdata;
                ccam_pkg::A_ADC_CTRL:  adc_ctrl_r <= reg_wdata;
                ccam_pkg::A_ENERGY:    energy_r   <= reg_wdata;
                default: ;
            endcase
        end
    end

    logic [1:0] em_mode;
    logic       lowest;
    assign em_mode = energy_r[ccam_pkg::B_EM_LO +: 2];
    assign lowest  = (em_mode == ccam_pkg::EM_LOWEST);
    // Regulators off and chosen coarse ones on in lowest mode
    always_ff @(posedge mclk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            regulator_on      <= 3'h0;
            coarse_reg_enable <= 3'h0;
        end else begin
            regulator_on      <= lowest ? 3'h0 : energy_r[ccam_pkg::B_REGEN_LO +: 3];
            coarse_reg_enable <= lowest ? energy_r[ccam_pkg::B_COARSE_LO +: 3] : 3'h0;
        end
    end
    assign first_conv_force_mode  = conv1_r[2:0];
    assign second_conv_force_mode = conv2_r[2:0];
    assign adc_use_secondary      = filt_r[4];

    // Calibration sequencer
    ccam_pkg::ccam_cal_e cal_st_r;
    logic [15:0] cal_pcnt_r, cal_target;
    logic        cal_start, cal_pulse;
    assign cal_start  = cmd_wr && reg_wdata[ccam_pkg::B_CMD_CAL] && !lowest;
    assign cal_target = ccam_pkg::CAL_PULSE_BASE << cal_cfg_r[ccam_pkg::B_NREQ_LO +: 3];
    assign cal_output_select = cal_cfg_r[ccam_pkg::B_SEL_LO +: 2];
    assign cal_load_level    = cal_cfg_r[ccam_pkg::B_LVL_LO +: 3];
    always_comb begin
        case (cal_output_select)
            2'h0:    cal_pulse = rise[0];
            2'h1:    cal_pulse = rise[1];
            2'h2:    cal_pulse = rise[2];
            default: cal_pulse = 1'b0;
        endcase
    end
    // Runs from start until the requested pulses, then holds the count
    always_ff @(posedge mclk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            cal_st_r   <= ccam_pkg::CAL_IDLE;
            cal_pcnt_r <= 16'h0000;
        end else begin
            case (cal_st_r)
                ccam_pkg::CAL_IDLE: begin
                    if (cal_start) begin
                        cal_st_r   <= ccam_pkg::CAL_RUN;
                        cal_pcnt_r <= 16'h0000;
                    end
                end
                ccam_pkg::CAL_RUN: begin
                    if (lowest) cal_st_r <= ccam_pkg::CAL_IDLE;
                    else if (cal_pulse) begin
                        cal_pcnt_r <= cal_pcnt_r + 16'h0001;
                        if (cal_pcnt_r + 16'h0001 >= cal_target)
                            cal_st_r <= ccam_pkg::CAL_IDLE;
                    end
                end
                default: cal_st_r <= ccam_pkg::CAL_IDLE;
            endcase
        end
    end
    assign cal_load_on = (cal_st_r == ccam_pkg::CAL_RUN);

    // Pulse routing and prescaled accumulators
    logic [3:0]  ev;
    logic        counting, counter_clear_bit;
    logic [3:0]  p_eff;
    logic [4:0]  shift;
    logic [15:0] unit_m1;
    logic [15:0] cnt_r [4];
    logic [15:0] pre_r [4];
    assign counting = counter_control_r[ccam_pkg::B_COUNTER_ENABLE_BIT] && !lowest && !cal_load_on;
    assign counter_clear_bit   = cmd_wr && reg_wdata[ccam_pkg::B_CMD_CCCLR];
    assign ev[ccam_pkg::P_FIRST]       = rise[0] && !filt_r[5];
    assign ev[ccam_pkg::P_SECOND_FULL] = rise[1] && (em_mode != ccam_pkg::EM_REDUCED);
    assign ev[ccam_pkg::P_SECOND_RED]  = rise[1] && (em_mode == ccam_pkg::EM_REDUCED);
    assign ev[ccam_pkg::P_THIRD]       = rise[2] || (rise[0] && filt_r[5]);
    assign p_eff = (counter_control_r[ccam_pkg::B_PRESCL_LO +: 4] > ccam_pkg::PRESCL_MAX)
                 ? ccam_pkg::PRESCL_MAX : counter_control_r[ccam_pkg::B_PRESCL_LO +: 4];
    assign shift   = ccam_pkg::PRESCL_BASE - {p_eff, 1'b0};
    assign unit_m1 = 16'(({1'b0, 16'h0000} | (17'h00001 << shift)) - 17'h00001);
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pair
            always_ff @(posedge mclk or negedge rst_ok_n) begin
                if (!rst_ok_n) begin
                    cnt_r[gi] <= 16'h0000;
                    pre_r[gi] <= 16'h0000;
                end else if (counter_clear_bit) begin
                    cnt_r[gi] <= 16'h0000;
                    pre_r[gi] <= 16'h0000;
                end else if (gi == ccam_pkg::P_THIRD && cal_start) begin
                    cnt_r[gi] <= 16'h0000;
                end else if (gi == ccam_pkg::P_THIRD && cal_load_on) begin
                    // Reference cycles counted unscaled during calibration
                    if (rise[3]) cnt_r[gi] <= cnt_r[gi] + 16'h0001;
                end else if (counting && ev[gi]) begin
                    if (pre_r[gi] >= unit_m1) begin
                        pre_r[gi] <= 16'h0000;
                        cnt_r[gi] <= cnt_r[gi] + 16'h0001;
                    end else begin
                        pre_r[gi] <= pre_r[gi] + 16'h0001;
                    end
                end
            end
        end
    endgenerate

    // Fill flag, set wins over a same-cycle clear
    logic [15:0] fill_lvl;
    logic        over, full_r, full_clr;
    always_comb begin
        case (counter_control_r[ccam_pkg::B_THRSH_LO +: 2])
            2'h0:    fill_lvl = ccam_pkg::FILL_50;
            2'h1:    fill_lvl = ccam_pkg::FILL_62;
            2'h2:    fill_lvl = ccam_pkg::FILL_75;
            default: fill_lvl = ccam_pkg::FILL_87;
        endcase
    end
    assign over = !cal_load_on && ((cnt_r[0] >= fill_lvl) || (cnt_r[1] >= fill_lvl)
               || (cnt_r[2] >= fill_lvl) || (cnt_r[3] >= fill_lvl));
    assign full_clr = reg_wr && (reg_addr == ccam_pkg::A_STATUS) && reg_wdata[0];
    always_ff @(posedge mclk or negedge rst_ok_n) begin
        if (!rst_ok_n)     full_r <= 1'b0;
        else if (over)     full_r <= 1'b1;
        else if (full_clr) full_r <= 1'b0;
    end
    // Pin pulled low while the flag is set and unmasked, never in lowest mode
    always_ff @(posedge mclk or negedge rst_ok_n) begin
        if (!rst_ok_n) irq_oe_n <= 1'b1;
        else           irq_oe_n <= !(full_r && mask_r[0] && !lowest);
    end
    assign irq_out = 1'b0;

    // Conversion triggers: manual command or pulse interval
    logic [2:0]  ivl;
    logic [10:0] trig_cnt_r, trig_lim;
    logic        any_ev, manual, start_r, busy_r;
    assign ivl      = adc_ctrl_r[ccam_pkg::B_IVL_LO +: 3];
    assign trig_lim = 11'(({7'h00, 4'h1} << ({1'b0, ivl} + ccam_pkg::IVL_OFFSET)) - 11'h001);
    assign any_ev   = counting && (|ev);
    assign manual   = cmd_wr && reg_wdata[ccam_pkg::B_CMD_ADC];
    always_ff @(posedge mclk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            trig_cnt_r <= 11'h000;
            start_r    <= 1'b0;
        end else begin
            start_r <= 1'b0;
            if (any_ev && ivl != 3'h0) begin
                trig_cnt_r <= (trig_cnt_r >= trig_lim) ? 11'h000 : trig_cnt_r + 11'h001;
                if (trig_cnt_r >= trig_lim && !lowest) start_r <= 1'b1;
            end
            if (manual && !lowest) start_r <= 1'b1;
        end
    end
    assign adc_start = start_r;

    // Working results: IIR average, extremes, temperature
    logic signed [20:0] acc_r, diff;
    logic [11:0] min_w, max_w, temp_w, avg_w;
    logic        clr_pend_r, adc_ok;
    assign adc_ok = adc_done && !lowest;
    assign diff   = $signed({2'b00, adc_voltage, 7'h00}) - acc_r;
    assign avg_w  = acc_r[18:7];
    always_ff @(posedge mclk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            acc_r      <= 21'sh000000;
            min_w      <= 12'hFFF;
            max_w      <= 12'h000;
            temp_w     <= 12'h000;
            clr_pend_r <= 1'b1;
        end else begin
            if (cmd_wr && reg_wdata[ccam_pkg::B_CMD_ADCCLR]) clr_pend_r <= 1'b1;
            if (adc_ok) begin
                temp_w <= adc_temperature;
                if (clr_pend_r) begin
                    acc_r      <= $signed({2'b00, adc_voltage, 7'h00});
                    min_w      <= adc_voltage;
                    max_w      <= adc_voltage;
                    clr_pend_r <= cmd_wr && reg_wdata[ccam_pkg::B_CMD_ADCCLR];
                end else begin
                    acc_r <= acc_r + (diff >>> adc_ctrl_r[ccam_pkg::B_TAU_LO +: 3]);
                    if (adc_voltage < min_w) min_w <= adc_voltage;
                    if (adc_voltage > max_w) max_w <= adc_voltage;
                end
            end
        end
    end

    // Visible pairs copy working values unless that pair is being addressed
    logic [11:0] vis_r [4];
    logic [11:0] work [4];
    assign work[0] = avg_w;
    assign work[1] = min_w;
    assign work[2] = max_w;
    assign work[3] = temp_w;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_vis
            logic held;
            assign held = reg_sel && (reg_addr[7:1] == 7'((ccam_pkg::A_ADC_BASE >> 1) + gi));
            always_ff @(posedge mclk or negedge rst_ok_n) begin
                if (!rst_ok_n)  vis_r[gi] <= 12'h000;
                else if (!held) vis_r[gi] <= work[gi];
            end
        end
    endgenerate

    // Read mux; upper ADC read captures lower byte for coherent pairs
    logic [7:0] radr_off;
    logic [1:0] ridx;
    assign radr_off = reg_addr - ccam_pkg::A_CNT_BASE;
    assign ridx     = radr_off[2:1];
    always_ff @(posedge mclk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            rdata_r  <= 8'h00;
            shadow_r <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr >= ccam_pkg::A_ADC_BASE && reg_addr <= ccam_pkg::A_ADC_LAST) begin
                if (!reg_addr[0]) begin
                    rdata_r  <= {4'h0, vis_r[ridx][11:8]};
                    shadow_r <= vis_r[ridx][7:0];
                end else begin
                    rdata_r <= shadow_r;
                end
            end else if (reg_addr >= ccam_pkg::A_CNT_BASE && reg_addr < ccam_pkg::A_ADC_BASE)
                rdata_r <= radr_off[0] ? cnt_r[ridx][7:0] : cnt_r[ridx][15:8];
            else begin
                case (reg_addr)
                    ccam_pkg::A_COUNTER_CONTROL:   rdata_r <= counter_control_r;
                    ccam_pkg::A_CAL_CFG:   rdata_r <= cal_cfg_r;
                    ccam_pkg::A_MODE_RPT:  rdata_r <= {2'h0, second_conv_mode_field,
                                                       first_conv_mode_field};
                    ccam_pkg::A_CONV1_CTL: rdata_r <= conv1_r;
                    ccam_pkg::A_CONV2_CTL: rdata_r <= conv2_r;
                    ccam_pkg::A_STATUS:    rdata_r <= {7'h00, full_r};
                    ccam_pkg::A_STAT_MASK: rdata_r <= mask_r;
                    ccam_pkg::A_ADC_CTRL:  rdata_r <= adc_ctrl_r;
                    ccam_pkg::A_ENERGY:    rdata_r <= energy_r;
                    default:               rdata_r <= 8'h00;
                endcase
            end
        end
    end
    assign reg_rdata = rdata_r;
endmodule : ccam_top

/* File: inc/ccam_pkg.sv */
// Constants for the charge counter and ADC monitor block.
// Assumes a byte-wide register transaction port fed by the I2C target logic.
package ccam_pkg;
    // Register indices on the byte port
    localparam logic [7:0] A_COUNTER_CONTROL   = 8'h00; // counter_control
    localparam logic [7:0] A_CMD       = 8'h01;
    localparam logic [7:0] A_CAL_CFG   = 8'h02; // calibration_config
    localparam logic [7:0] A_MODE_RPT  = 8'h03; // converter_mode_report
    localparam logic [7:0] A_CONV1_CTL = 8'h04; // first_conv_control
    localparam logic [7:0] A_CONV2_CTL = 8'h05; // second_conv_control
    localparam logic [7:0] A_STATUS    = 8'h06;
    localparam logic [7:0] A_STAT_MASK = 8'h07; // general_status_mask
    localparam logic [7:0] A_ADC_CTRL  = 8'h08; // conversion_counter_control
    localparam logic [7:0] A_ENERGY    = 8'h09; // energy_coarse_control
    localparam logic [7:0] A_CNT_BASE  = 8'h0A; // 4 count pairs, upper then lower
    localparam logic [7:0] A_ADC_BASE  = 8'h12; // avg, min, max, temp pairs
    localparam logic [7:0] A_ADC_LAST  = 8'h19;
    // Field positions
    localparam int B_COUNTER_ENABLE_BIT = 0;
    localparam int B_PRESCL_LO = 1;
    localparam int B_THRSH_LO = 5;
    localparam int B_CMD_CAL = 0;
    localparam int B_CMD_CCCLR = 1;
    localparam int B_CMD_ADC = 2;
    localparam int B_CMD_ADCCLR = 3;
    localparam int B_SEL_LO = 0;
    localparam int B_NREQ_LO = 2;
    localparam int B_LVL_LO = 5;
    localparam int B_TAU_LO = 0;
    localparam int B_IVL_LO = 4;
    localparam int B_REGEN_LO = 0;
    localparam int B_COARSE_LO = 3;
    localparam int B_EM_LO = 6;
    // Energy modes
    localparam logic [1:0] EM_FULL = 2'h0;
    localparam logic [1:0] EM_REDUCED = 2'h1;
    localparam logic [1:0] EM_LOWEST = 2'h2;
    // Count pair indices
    localparam int P_FIRST = 0;
    localparam int P_SECOND_FULL = 1;
    localparam int P_SECOND_RED = 2;
    localparam int P_THIRD = 3;
    // Fill levels: 50%, 62.5%, 75%, 87% of 16 bits
    localparam logic [15:0] FILL_50 = 16'h8000;
    localparam logic [15:0] FILL_62 = 16'hA000;
    localparam logic [15:0] FILL_75 = 16'hC000;
    localparam logic [15:0] FILL_87 = 16'hDEB8;
    // Prescaler: unit is 2^(16-2p); p above 8 acts as 8
    localparam logic [3:0] PRESCL_MAX = 4'h8;
    localparam logic [4:0] PRESCL_BASE = 5'h10;
    // Calibration pulse target is 16 << cal_pulse_count
    localparam logic [15:0] CAL_PULSE_BASE = 16'h0010;
    localparam logic [3:0] IVL_OFFSET = 4'h3;
    localparam int IIR_FRAC = 7;
    localparam int SYNC_W = 6;
    typedef enum logic [0:0] {CAL_IDLE = 1'b0, CAL_RUN = 1'b1} ccam_cal_e;
endpackage : ccam_pkg

/* File: tb/ccam_props.sv */
// Checker for the charge counter and ADC monitor top.
// Assumes it is bound to ccam_top and sees only its ports.
`timescale 1ns/100ps
module ccam_props (
    // Clock, reset and register writes
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    // Watched outputs
    input wire logic       adc_start,
    input wire logic [2:0] regulator_on,
    input wire logic [2:0] coarse_reg_enable,
    input wire logic [2:0] first_conv_force_mode,
    input wire logic [2:0] second_conv_force_mode,
    input wire logic       cal_load_on,
    input wire logic [1:0] cal_output_select,
    input wire logic [2:0] cal_load_level,
    input wire logic       irq_out,
    input wire logic       irq_oe_n
);
    logic [7:0] nrg_r, cfg_r, c1_r, c2_r;
    logic       mask_r;
    // Mirror of host writes, so outputs can be tied to their cause
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {nrg_r, cfg_r, c1_r, c2_r, mask_r} <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                ccam_pkg::A_ENERGY:    nrg_r <= reg_wdata;
                ccam_pkg::A_CAL_CFG:   cfg_r <= reg_wdata;
                ccam_pkg::A_CONV1_CTL: c1_r <= reg_wdata;
                ccam_pkg::A_CONV2_CTL: c2_r <= reg_wdata;
                ccam_pkg::A_STAT_MASK: mask_r <= reg_wdata[0];
                default: ;
            endcase
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Two cycles in lowest mode, so registered outputs have caught up
    sequence s_lowest;
        nrg_r[7:6] == ccam_pkg::EM_LOWEST ##1 nrg_r[7:6] == ccam_pkg::EM_LOWEST;
    endsequence
    sequence s_cmd(int b);
        reg_wr && reg_addr == ccam_pkg::A_CMD && reg_wdata[b]
            && nrg_r[7:6] != ccam_pkg::EM_LOWEST;
    endsequence
    AST_LOW_REGS: assert property (s_lowest |-> regulator_on == 3'h0
        && coarse_reg_enable == $past(nrg_r[5:3])) else $error("lowest mode outputs wrong");
    AST_LOW_NO_ADC: assert property (s_lowest |-> !adc_start)
        else $error("conversion started in lowest mode");
    AST_LOW_NO_IRQ: assert property (s_lowest |-> irq_oe_n)
        else $error("interrupt driven in lowest mode");
    AST_ADC_CMD: assert property (s_cmd(ccam_pkg::B_CMD_ADC) |-> ##[1:3] adc_start)
        else $error("manual conversion not started");
    AST_CAL_RUN: assert property (s_cmd(ccam_pkg::B_CMD_CAL) |-> ##[1:3] cal_load_on)
        else $error("calibration load not applied");
    AST_CAL_CFG: assert property ($stable(cfg_r) |-> cal_output_select == cfg_r[1:0]
        && cal_load_level == cfg_r[7:5]) else $error("calibration fields wrong");
    AST_FORCE: assert property ($stable({c1_r, c2_r}) |->
        first_conv_force_mode == c1_r[2:0] && second_conv_force_mode == c2_r[2:0])
        else $error("forced mode fields wrong");
    AST_IRQ_MASK: assert property (!mask_r && !$past(mask_r) |-> irq_oe_n)
        else $error("interrupt while masked");
    AST_IRQ_PIN: assert property (irq_out == 1'b0)
        else $error("interrupt pin driven high");
endmodule : ccam_props
bind ccam_top ccam_props u_props (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .adc_start(adc_start),
    .regulator_on(regulator_on), .coarse_reg_enable(coarse_reg_enable),
    .first_conv_force_mode(first_conv_force_mode),
    .second_conv_force_mode(second_conv_force_mode), .cal_load_on(cal_load_on),
    .cal_output_select(cal_output_select), .cal_load_level(cal_load_level),
    .irq_out(irq_out), .irq_oe_n(irq_oe_n));

/* File: tb/ccam_adc_model.sv */
// Behavioural ADC macro answering conversion requests.
// Assumes the bench sets the voltage and temperature to return.
`timescale 1ns/100ps
module ccam_adc_model (
    // Clock and request
    input  wire logic        mclk,
    input  wire logic        adc_start,
    // Values to return
    input  wire logic [11:0] volt,
    input  wire logic [11:0] temp,
    // Answer
    output logic             adc_done,
    output logic [11:0]      adc_voltage,
    output logic [11:0]      adc_temperature
);
    // Data is only valid with done; scrambled after, so stale reuse shows
    initial begin
        {adc_done, adc_voltage, adc_temperature} = '0;
        forever begin
            @(posedge mclk);
            if (adc_start) begin
                repeat (6) @(posedge mclk);
                #1;
                {adc_done, adc_voltage, adc_temperature} = {1'b1, volt, temp};
                @(posedge mclk);
                #1;
                {adc_done, adc_voltage, adc_temperature} = {1'b0, ~volt, ~temp};
            end
        end
    end
endmodule : ccam_adc_model

/* File: tb/tb_top.sv */
// Self-checking bench for the charge counter and ADC monitor block.
// Assumes the ADC model on the far side and a free 10 MHz reference.
`timescale 1ns/100ps
module tb_top;
    logic        mclk = 1'b0, rst_n = 1'b0, reg_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        ref_10mhz = 1'b0, sec_ok = 1'b0, ldo3 = 1'b0;
    logic        adc_done, adc_start, adc_use_sec, cal_load_on, irq_oe_n;
    logic [2:0]  pls = 3'h0, regulator_on, coarse_reg_enable;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, hi, lo;
    logic [11:0] volt = 12'h000, temp = 12'h123, adc_voltage, adc_temperature;
    int          num_errors = 0, compares = 0;
    ccam_top uut (.mclk(mclk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .first_output_pulse(pls[0]), .second_output_pulse(pls[1]),
        .third_output_pulse(pls[2]), .ref_10mhz(ref_10mhz),
        .secondary_supply_valid(sec_ok), .third_ldo_powering(ldo3),
        .first_conv_mode_field(3'h5), .second_conv_mode_field(3'h2),
        .adc_start(adc_start), .adc_use_secondary(adc_use_sec), .adc_done(adc_done),
        .adc_voltage(adc_voltage), .adc_temperature(adc_temperature),
        .regulator_on(regulator_on), .coarse_reg_enable(coarse_reg_enable),
        .first_conv_force_mode(), .second_conv_force_mode(), .cal_load_on(cal_load_on),
        .cal_output_select(), .cal_load_level(), .irq_out(), .irq_oe_n(irq_oe_n));
    ccam_adc_model u_adc (.mclk(mclk), .adc_start(adc_start), .volt(volt), .temp(temp),
        .adc_done(adc_done), .adc_voltage(adc_voltage), .adc_temperature(adc_temperature));
    // Clocks; the reference is offset so it has no fixed phase to mclk
    initial forever #4 mclk = ~mclk;
    initial begin
        #13;
        forever #50 ref_10mhz = ~ref_10mhz;
    end
    task automatic end_of_test();
        if (num_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // Inputs always move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        {reg_sel, reg_wr, reg_addr, reg_wdata} = {2'b11, a, d};
        tick(1);
        {reg_sel, reg_wr} = 2'b00;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        tick(1);
        {reg_sel, reg_rd, reg_addr} = {2'b11, a};
        tick(1);
        {reg_sel, reg_rd} = 2'b00;
        d = reg_rdata;
    endtask : rd
    task automatic pair(input logic [7:0] a, input logic [15:0] exp);
        rd(a, hi);
        rd(a + 8'h01, lo);
        chk({hi, lo}, exp);
    endtask : pair
    // High held 4 cycles and low 5 between pulses, longer than the input filter needs
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            tick(1);
            pls[k] = 1'b1;
            tick(4);
            pls[k] = 1'b0;
            tick(4);
        end
        tick(6);
    endtask : pulse
    task automatic conv(input logic [11:0] v);
        volt = v;
        wr(ccam_pkg::A_CMD, 8'h04);
        for (int i = 0; i < 40 && adc_done !== 1'b1; i++) @(posedge mclk);
        if (adc_done !== 1'b1) begin
            num_errors++;
            end_of_test();
        end
        tick(4);
    endtask : conv
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
    // Main sequence: ADC results, counting, lowest mode, calibration
    initial begin
        tick(2);
        rst_n = 1'b1;
        tick(3);
        conv(12'hABC);
        for (int i = 0; i < 3; i++) pair(8'h12 + 8'(2 * i), 16'h0ABC);
        pair(8'h18, 16'h0123);
        conv(12'h400);
        pair(8'h14, 16'h0400);
        pair(8'h16, 16'h0ABC);
        pair(8'h12, 16'h0400);
        wr(ccam_pkg::A_ADC_CTRL, 8'h01);
        conv(12'h600);
        pair(8'h12, 16'h0500);
        rd(8'h12, hi);
        conv(12'h7FF);
        rd(8'h13, lo);
        chk({hi, lo}, 16'h0500);
        wr(ccam_pkg::A_CMD, 8'h08);
        conv(12'h222);
        pair(8'h16, 16'h0222);
        sec_ok = 1'b1;
        tick(10);
        chk(adc_use_sec, 1'b1);
        rd(ccam_pkg::A_MODE_RPT, lo);
        chk(lo, 8'h15);
        wr(ccam_pkg::A_COUNTER_CONTROL, 8'h11);
        pulse(0, 3);
        pair(8'h0A, 16'h0003);
        ldo3 = 1'b1;
        pulse(0, 2);
        ldo3 = 1'b0;
        pair(8'h10, 16'h0002);
        wr(ccam_pkg::A_ENERGY, 8'h47);
        pulse(1, 1);
        pair(8'h0E, 16'h0001);
        wr(ccam_pkg::A_ENERGY, 8'h07);
        pulse(1, 2);
        pair(8'h0C, 16'h0002);
        chk({regulator_on, coarse_reg_enable}, 6'h38);
        wr(ccam_pkg::A_CMD, 8'h02);
        pair(8'h0A, 16'h0000);
        pair(8'h10, 16'h0000);
        wr(ccam_pkg::A_COUNTER_CONTROL, 8'h0F);
        pulse(0, 7);
        pair(8'h0A, 16'h0001);
        wr(ccam_pkg::A_COUNTER_CONTROL, 8'h0E);
        pulse(0, 4);
        pair(8'h0A, 16'h0001);
        wr(ccam_pkg::A_COUNTER_CONTROL, 8'h11);
        wr(ccam_pkg::A_ENERGY, 8'hAF);
        wr(ccam_pkg::A_CMD, 8'h04);
        pulse(0, 2);
        chk({regulator_on, coarse_reg_enable}, 6'h05);
        pair(8'h0A, 16'h0001);
        rd(8'h3C, lo);
        chk(lo, 8'h00);
        wr(ccam_pkg::A_ENERGY, 8'h07);
        temp = 12'h456;
        wr(ccam_pkg::A_ADC_CTRL, 8'h11);
        pulse(0, 15);
        pair(8'h18, 16'h0123);
        pulse(0, 1);
        pair(8'h18, 16'h0456);
        wr(ccam_pkg::A_COUNTER_CONTROL, 8'h10);
        wr(ccam_pkg::A_CAL_CFG, 8'h62);
        wr(ccam_pkg::A_CMD, 8'h01);
        tick(3);
        chk(cal_load_on, 1'b1);
        pulse(2, 16);
        chk(cal_load_on, 1'b0);
        rd(8'h10, hi);
        rd(8'h11, lo);
        chk({hi, lo} > 16'h0005 && {hi, lo} < 16'h0014, 1'b1);
        pulse(2, 2);
        pair(8'h10, {hi, lo});
        end_of_test();
    end
endmodule : tb_top
